// ==== rtl/sfr_pkg.sv ====
// shared constants and types of the serial lane fault recovery controller
package sfr_pkg;
  // ----------------------------------------------------------------
  // sizes and clock
  // ----------------------------------------------------------------
  localparam int LANES = 4;
  localparam int REGS_PER_LANE = 8;
  localparam int REF_DW = 33;
  localparam int CLK_HZ = 25_000_000;
  localparam int MAX_CFG_CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // ----------------------------------------------------------------
  // software register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_STATUS = 6'h04;
  localparam logic [5:0] OFF_MASK = 6'h08;
  localparam logic [5:0] OFF_BURST = 6'h0c;
  localparam logic [5:0] OFF_LIMITS = 6'h10;
  localparam logic [5:0] OFF_CLKSHARE = 6'h14;
  localparam logic [5:0] OFF_REF_ADDR = 6'h18;
  localparam logic [5:0] OFF_REF_DATA = 6'h1c;
  localparam logic [5:0] OFF_STATE = 6'h20;
  localparam logic [5:0] OFF_RETRIES = 6'h24;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_PCIE_XAUI = 1;
  localparam int CTRL_FORCE_INIT = 2;
  localparam int ST_W = 5;
  localparam int EV_RETRY = 0;
  localparam int EV_DISCONNECT = 1;
  localparam int EV_FUNC_INT = 2;
  localparam int EV_INIT_RESET = 3;
  localparam int EV_RECOVERED = 4;
  localparam int REF_NEED_READY = 16;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [ST_W-1:0] MASK_RST = 5'h00;
  localparam logic [7:0] THRESH_RST = 8'h04;
  localparam logic [15:0] WINDOW_RST = 16'h0100;
  localparam logic [3:0] RETRY_LIMIT_RST = 4'h3;
  localparam logic [11:0] HOLD_RST = 12'h010;
  // ----------------------------------------------------------------
  // transceiver configuration map
  // ----------------------------------------------------------------
  localparam logic [15:0] DEV_LANE_BASE = 16'h1000;
  localparam logic [15:0] DEV_LANE_STRIDE = 16'h0400;
  localparam logic [15:0] DEV_APPLY_OFF = 16'h0300;
  localparam logic [31:0] DEV_APPLY_VALUE = 32'h00000001;
  // ----------------------------------------------------------------
  // timing: a link gets this long to come up, a least time
  // ----------------------------------------------------------------
  localparam int LINK_WAIT_NS = 1_000_000;
  localparam int LINK_WAIT_CYCLES = (LINK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SOFT, ST_PHYRST, ST_RD, ST_FETCH, ST_SETUP, ST_ACCESS, ST_WAIT, ST_INIT
  } sfr_state_type;
endpackage

// ==== rtl/sfr_mem_if.sv ====
// port bundle between the recovery sequencer and its reference memory
`timescale 1ns/1ps
interface sfr_mem_if #(parameter int AW = 5, parameter int DW = 33);
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  modport ctrl (output rd_en, output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
  modport mem (input rd_en, input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface

// ==== rtl/sfr_ref_mem.sv ====
// reference copy of every lane's analogue settings, registered read
`timescale 1ns/1ps
module sfr_ref_mem #(
  parameter int AW = 5,
  parameter int DW = 33
) (
  input wire logic mclk,
  input wire logic rst_n,
  sfr_mem_if.mem port
);
  logic [DW-1:0] store [0:(1<<AW)-1];
  logic [DW-1:0] next_rd_data;

  initial begin
    if (AW < 1 || DW < 1) $error("sfr_ref_mem: bad size");
  end

  // read data hold until the next read, so the sequencer may wait on it
  always_comb begin
    next_rd_data = port.rd_en ? store[port.rd_addr] : port.rd_data;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      port.rd_data <= '0;
    else
      port.rd_data <= next_rd_data;
  end

  // array carries no reset: software loads it before enabling recovery
  always_ff @(posedge mclk)
  begin
    if (port.wr_en)
      store[port.wr_addr] <= port.wr_data;
  end
endmodule

// ==== rtl/sfr_lane_mon.sv ====
// per-lane fault watcher: error bursts, lock and receive-valid loss
`timescale 1ns/1ps
module sfr_lane_mon (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic blank,
  input wire logic cdr_lock,
  input wire logic rx_valid,
  input wire logic err,
  input wire logic [7:0] thresh,
  input wire logic [15:0] window,
  output logic disconnect
);
  logic [15:0] win_cnt;
  logic [7:0] err_cnt;
  logic [15:0] next_win_cnt;
  logic [7:0] next_err_cnt;
  logic next_disconnect;
  logic burst;

  // errors are counted inside a fixed window; a blanked lane restarts clean
  always_comb begin
    next_win_cnt = win_cnt;
    next_err_cnt = err_cnt;
    if (blank) begin
      next_win_cnt = window;
      next_err_cnt = 8'h00;
    end else if (win_cnt == 16'h0000) begin
      next_win_cnt = window;
      next_err_cnt = {7'h00, err};
    end else begin
      next_win_cnt = win_cnt - 16'h0001;
      if (err && err_cnt != 8'hff)
        next_err_cnt = err_cnt + 8'h01;
    end
    burst = (thresh != 8'h00) && (next_err_cnt >= thresh);
    next_disconnect = !blank && (burst || !cdr_lock || !rx_valid);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) begin
      win_cnt <= 16'h0000;
      err_cnt <= 8'h00;
      disconnect <= 1'b0;
    end else begin
      win_cnt <= next_win_cnt;
      err_cnt <= next_err_cnt;
      disconnect <= next_disconnect;
    end
  end
endmodule

// ==== rtl/sfr_top.sv ====
// serial lane fault recovery controller: detection, escalation, reload
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - last resort pulses transceiver initialization reset
// - domain pll lock loss is a fault in the pcie and xaui modes
// - resent frames counted as retry, never reset
// - error burst within window means disconnection
// - lock or valid loss: reinitialize the lane
// - failure after pma reset: reload lane settings
// - some settings written only once pma ready
// - reset phy, rewrite settings, then write apply
// - configuration clock at most 50 MHz
// - reference copy of all lane settings kept
// - pll lock never used as reset source
module sfr_top #(
  parameter int LANES = sfr_pkg::LANES,
  parameter int REGS_PER_LANE = sfr_pkg::REGS_PER_LANE,
  parameter int LINK_WAIT_CYCLES = sfr_pkg::LINK_WAIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic irq,
  input wire logic [LANES-1:0] cdr_lock,
  input wire logic [LANES-1:0] lane_receive_valid,
  input wire logic [LANES-1:0] pma_ready,
  input wire logic domain_pll_lock,
  input wire logic [LANES-1:0] lane_error,
  input wire logic [LANES-1:0] lane_retry,
  input wire logic [LANES-1:0] lane_link_up,
  output logic [LANES-1:0] lane_down,
  output logic [LANES-1:0] lane_soft_reset_request,
  output logic [LANES-1:0] lane_pcs_reset_low,
  output logic core_reset_low,
  output logic init_reset_low,
  output logic [15:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic pready
);
  localparam int LW = 2;
  localparam int IW = $clog2(REGS_PER_LANE);
  localparam int AW = LW + IW;
  localparam int TW = $clog2(LINK_WAIT_CYCLES + 1);

  initial begin
    if (LANES != 4) $error("sfr_top: lane field is sized for four lanes");
    if (REGS_PER_LANE < 2 || REGS_PER_LANE != (1 << IW)) $error("sfr_top: regs per lane must be a power of two");
    if (LINK_WAIT_CYCLES < 2) $error("sfr_top: link wait too short");
    if (sfr_pkg::CLK_HZ > sfr_pkg::MAX_CFG_CLK_HZ) $error("sfr_top: configuration clock too fast");
  end

  // ----------------------------------------------------------------
  // synchronisers for transceiver status pins
  // ----------------------------------------------------------------
  logic [3*LANES:0] sync_a;
  logic [3*LANES:0] sync_b;
  logic [LANES-1:0] cdr_s;
  logic [LANES-1:0] valid_s;
  logic [LANES-1:0] ready_s;
  logic pll_s;

  // two flops each; only the second stage is ever looked at
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {domain_pll_lock, pma_ready, lane_receive_valid, cdr_lock};
      sync_b <= sync_a;
    end
  end
  assign cdr_s = sync_b[LANES-1:0];
  assign valid_s = sync_b[2*LANES-1:LANES];
  assign ready_s = sync_b[3*LANES-1:2*LANES];
  assign pll_s = sync_b[3*LANES];

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [1:0] ctrl;
  logic [sfr_pkg::ST_W-1:0] status;
  logic [sfr_pkg::ST_W-1:0] mask;
  logic [7:0] thresh;
  logic [15:0] window;
  logic [3:0] retry_limit;
  logic [11:0] hold_limit;
  logic [LW-1:0] clk_master;
  logic [LANES-1:0] clk_dep;
  logic [AW-1:0] ref_idx;
  logic ref_need_ready;
  logic [15:0] retries;
  logic [1:0] next_ctrl;
  logic [sfr_pkg::ST_W-1:0] next_status;
  logic [sfr_pkg::ST_W-1:0] next_mask;
  logic [7:0] next_thresh;
  logic [15:0] next_window;
  logic [3:0] next_retry_limit;
  logic [11:0] next_hold_limit;
  logic [LW-1:0] next_clk_master;
  logic [LANES-1:0] next_clk_dep;
  logic [AW-1:0] next_ref_idx;
  logic next_ref_need_ready;
  logic [15:0] next_retries;
  logic [31:0] next_sw_rdata;
  logic next_irq;
  logic [sfr_pkg::ST_W-1:0] set_ev;
  logic force_init;
  logic [LANES-1:0] disc;
  // sequencer state, declared here because the OFF_STATE read-back reports it
  sfr_pkg::sfr_state_type state;
  sfr_pkg::sfr_state_type next_state;
  logic [LW-1:0] lane;
  logic [LW-1:0] next_lane;
  logic [1:0] level;
  logic [1:0] next_level;

  sfr_mem_if #(.AW(AW), .DW(sfr_pkg::REF_DW)) mem_bus ();

  sfr_ref_mem #(.AW(AW), .DW(sfr_pkg::REF_DW)) u_ref_mem (
    .mclk(mclk),
    .rst_n(rst_n),
    .port(mem_bus.mem)
  );

  assign force_init = sw_wr && sw_addr == sfr_pkg::OFF_CTRL && sw_wdata[sfr_pkg::CTRL_FORCE_INIT];
  // software loads the reference copy through an index and a data word
  assign mem_bus.wr_en = sw_wr && sw_addr == sfr_pkg::OFF_REF_DATA;
  assign mem_bus.wr_addr = ref_idx;
  assign mem_bus.wr_data = {ref_need_ready, sw_wdata};

  // register writes; a hardware set wins over a write-one clear
  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_thresh = thresh;
    next_window = window;
    next_retry_limit = retry_limit;
    next_hold_limit = hold_limit;
    next_clk_master = clk_master;
    next_clk_dep = clk_dep;
    next_ref_idx = ref_idx;
    next_ref_need_ready = ref_need_ready;
    next_status = status | set_ev;
    next_retries = retries + {15'h0000, set_ev[sfr_pkg::EV_RETRY] && retries != 16'hffff};
    if (sw_wr) begin
      case (sw_addr)
        sfr_pkg::OFF_CTRL: next_ctrl = sw_wdata[1:0];
        sfr_pkg::OFF_STATUS: next_status = (status & ~sw_wdata[sfr_pkg::ST_W-1:0]) | set_ev;
        sfr_pkg::OFF_MASK: next_mask = sw_wdata[sfr_pkg::ST_W-1:0];
        sfr_pkg::OFF_BURST:
        begin
          next_thresh = sw_wdata[7:0];
          next_window = sw_wdata[23:8];
        end
        sfr_pkg::OFF_LIMITS:
        begin
          next_retry_limit = sw_wdata[3:0];
          next_hold_limit = sw_wdata[15:4];
        end
        sfr_pkg::OFF_CLKSHARE:
        begin
          next_clk_master = sw_wdata[LW-1:0];
          next_clk_dep = sw_wdata[8+LANES-1:8];
        end
        sfr_pkg::OFF_REF_ADDR:
        begin
          next_ref_idx = sw_wdata[AW-1:0];
          next_ref_need_ready = sw_wdata[sfr_pkg::REF_NEED_READY];
        end
        sfr_pkg::OFF_REF_DATA: next_ref_idx = ref_idx + {{(AW-1){1'b0}}, 1'b1};
        default: next_ctrl = ctrl;
      endcase
    end
    next_sw_rdata = 32'h00000000;
    if (sw_rd) begin
      case (sw_addr)
        sfr_pkg::OFF_CTRL: next_sw_rdata = {30'h00000000, ctrl};
        sfr_pkg::OFF_STATUS: next_sw_rdata = {27'h0000000, status};
        sfr_pkg::OFF_MASK: next_sw_rdata = {27'h0000000, mask};
        sfr_pkg::OFF_BURST: next_sw_rdata = {8'h00, window, thresh};
        sfr_pkg::OFF_LIMITS: next_sw_rdata = {16'h0000, hold_limit, retry_limit};
        sfr_pkg::OFF_CLKSHARE: next_sw_rdata = {20'h00000, clk_dep, 6'h00, clk_master};
        sfr_pkg::OFF_REF_ADDR: next_sw_rdata = {15'h0000, ref_need_ready, 11'h000, ref_idx};
        sfr_pkg::OFF_STATE: next_sw_rdata = {12'h000, disc, lane_down, 4'h0, level, lane, 4'(state)};
        sfr_pkg::OFF_RETRIES: next_sw_rdata = {16'h0000, retries};
        default: next_sw_rdata = 32'h00000000;
      endcase
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) begin
      ctrl <= sfr_pkg::CTRL_RST;
      status <= '0;
      mask <= sfr_pkg::MASK_RST;
      thresh <= sfr_pkg::THRESH_RST;
      window <= sfr_pkg::WINDOW_RST;
      retry_limit <= sfr_pkg::RETRY_LIMIT_RST;
      hold_limit <= sfr_pkg::HOLD_RST;
      clk_master <= '0;
      clk_dep <= '0;
      ref_idx <= '0;
      ref_need_ready <= 1'b0;
      retries <= 16'h0000;
      sw_rdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      status <= next_status;
      mask <= next_mask;
      thresh <= next_thresh;
      window <= next_window;
      retry_limit <= next_retry_limit;
      hold_limit <= next_hold_limit;
      clk_master <= next_clk_master;
      clk_dep <= next_clk_dep;
      ref_idx <= next_ref_idx;
      ref_need_ready <= next_ref_need_ready;
      retries <= next_retries;
      sw_rdata <= next_sw_rdata;
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // lane monitors
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : gen_mon
      sfr_lane_mon u_mon (
        .mclk(mclk),
        .rst_n(rst_n),
        .blank(lane_down[g]),
        .cdr_lock(cdr_s[g]),
        .rx_valid(valid_s[g]),
        .err(lane_error[g]),
        .thresh(thresh),
        .window(window),
        .disconnect(disc[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // recovery sequencer
  // ----------------------------------------------------------------
  logic [3:0] fails;
  logic [3:0] next_fails;
  logic [11:0] hold;
  logic [11:0] next_hold;
  logic [TW-1:0] tmo;
  logic [TW-1:0] next_tmo;
  logic [IW-1:0] idx;
  logic [IW-1:0] next_idx;
  logic apply;
  logic next_apply;
  logic [15:0] next_paddr;
  logic [31:0] next_pwdata;
  logic failed;
  logic pll_fault;
  logic [LANES-1:0] fault;
  logic [15:0] lane_base;
  logic [11:0] hold_min;

  // the pll lock only raises a fault, it never drives a reset directly
  assign pll_fault = ctrl[sfr_pkg::CTRL_PCIE_XAUI] && !pll_s;
  assign fault = disc | {{(LANES-1){1'b0}}, pll_fault};
  assign lane_base = 16'(sfr_pkg::DEV_LANE_BASE + 16'(lane) * sfr_pkg::DEV_LANE_STRIDE);
  assign hold_min = (hold_limit == 12'h000) ? 12'h001 : hold_limit;
  assign mem_bus.rd_en = (state == sfr_pkg::ST_RD);
  assign mem_bus.rd_addr = {lane, idx};

  always_comb begin
    next_state = state;
    next_lane = lane;
    next_level = level;
    next_fails = fails;
    next_hold = hold;
    next_tmo = tmo;
    next_idx = idx;
    next_apply = apply;
    next_paddr = paddr;
    next_pwdata = pwdata;
    failed = 1'b0;
    set_ev = '0;
    set_ev[sfr_pkg::EV_RETRY] = |lane_retry;
    case (state)
      sfr_pkg::ST_IDLE:
      begin
        if (force_init) begin
          next_level = 2'd3;
          next_hold = 12'h000;
          next_state = sfr_pkg::ST_INIT;
          set_ev[sfr_pkg::EV_INIT_RESET] = 1'b1;
        end else if (ctrl[sfr_pkg::CTRL_ENABLE] && |fault) begin
          for (int i = LANES - 1; i >= 0; i--)
            if (fault[i])
              next_lane = LW'(i);
          next_level = 2'd0;
          next_fails = 4'h0;
          next_hold = 12'h000;
          next_state = sfr_pkg::ST_SOFT;
          set_ev[sfr_pkg::EV_DISCONNECT] = 1'b1;
        end
      end
      sfr_pkg::ST_SOFT, sfr_pkg::ST_PHYRST, sfr_pkg::ST_INIT:
      begin
        next_hold = hold + 12'h001;
        if (next_hold >= hold_min) begin
          next_hold = 12'h000;
          next_tmo = '0;
          next_idx = '0;
          next_apply = 1'b0;
          if (state == sfr_pkg::ST_PHYRST && level == 2'd2)
            next_state = sfr_pkg::ST_RD;
          else
            next_state = sfr_pkg::ST_WAIT;
        end
      end
      sfr_pkg::ST_RD: next_state = sfr_pkg::ST_FETCH;
      sfr_pkg::ST_FETCH:
      begin
        if (apply) begin
          next_paddr = 16'(lane_base + sfr_pkg::DEV_APPLY_OFF);
          next_pwdata = sfr_pkg::DEV_APPLY_VALUE;
          next_state = sfr_pkg::ST_SETUP;
        end else if (!mem_bus.rd_data[32] || ready_s[lane]) begin
          next_paddr = 16'(lane_base + {idx, 2'b00});
          next_pwdata = mem_bus.rd_data[31:0];
          next_state = sfr_pkg::ST_SETUP;
        end else begin
          next_tmo = TW'(tmo + 1'b1);
          failed = (tmo >= TW'(LINK_WAIT_CYCLES - 1));
        end
      end
      sfr_pkg::ST_SETUP: next_state = sfr_pkg::ST_ACCESS;
      sfr_pkg::ST_ACCESS:
      begin
        if (pready) begin
          if (apply) begin
            next_tmo = '0;
            next_state = sfr_pkg::ST_WAIT;
          end else if (idx == IW'(REGS_PER_LANE - 1)) begin
            next_apply = 1'b1;
            next_state = sfr_pkg::ST_FETCH;
          end else begin
            next_idx = idx + {{(IW-1){1'b0}}, 1'b1};
            next_state = sfr_pkg::ST_RD;
          end
        end
      end
      sfr_pkg::ST_WAIT:
      begin
        if (lane_link_up[lane] && (level == 2'd3 || !fault[lane])) begin
          next_fails = 4'h0;
          next_state = sfr_pkg::ST_IDLE;
          set_ev[sfr_pkg::EV_RECOVERED] = 1'b1;
        end else begin
          next_tmo = TW'(tmo + 1'b1);
          failed = (tmo >= TW'(LINK_WAIT_CYCLES - 1));
        end
      end
      default: next_state = sfr_pkg::ST_IDLE;
    endcase
    // escalation after a timed-out attempt
    if (failed) begin
      next_tmo = '0;
      next_hold = 12'h000;
      case (level)
        2'd0:
        begin
          if (fails + 4'h1 >= retry_limit) begin
            next_level = 2'd1;
            next_fails = 4'h0;
            next_state = sfr_pkg::ST_PHYRST;
          end else begin
            next_fails = fails + 4'h1;
            next_state = sfr_pkg::ST_SOFT;
          end
        end
        2'd1:
        begin
          next_level = 2'd2;
          next_state = sfr_pkg::ST_PHYRST;
          set_ev[sfr_pkg::EV_FUNC_INT] = 1'b1;
        end
        default:
        begin
          next_level = 2'd3;
          next_state = sfr_pkg::ST_INIT;
          set_ev[sfr_pkg::EV_INIT_RESET] = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive, computed from the next state so every pin is a flop
  // ----------------------------------------------------------------
  logic [LANES-1:0] next_onehot;
  logic [LANES-1:0] next_lane_down;
  logic in_phy;
  logic next_soft;

  always_comb begin
    next_onehot = LANES'(1) << next_lane;
    next_soft = (next_state == sfr_pkg::ST_SOFT);
    in_phy = next_state inside {sfr_pkg::ST_PHYRST, sfr_pkg::ST_RD, sfr_pkg::ST_FETCH,
                                sfr_pkg::ST_SETUP, sfr_pkg::ST_ACCESS};
    next_lane_down = next_onehot;
    if (next_lane == clk_master)
      next_lane_down = next_lane_down | clk_dep;
    if (next_level >= 2'd1)
      next_lane_down = next_lane_down | (LANES'(1) << (next_lane ^ 2'b01));
    if (next_level == 2'd3)
      next_lane_down = '1;
    if (next_state == sfr_pkg::ST_IDLE)
      next_lane_down = '0;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) begin
      state <= sfr_pkg::ST_IDLE;
      lane <= '0;
      level <= 2'd0;
      fails <= 4'h0;
      hold <= 12'h000;
      tmo <= '0;
      idx <= '0;
      apply <= 1'b0;
      paddr <= 16'h0000;
      pwdata <= 32'h00000000;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      lane_down <= '0;
      lane_soft_reset_request <= '0;
      lane_pcs_reset_low <= '1;
      core_reset_low <= 1'b1;
      init_reset_low <= 1'b1;
    end else begin
      state <= next_state;
      lane <= next_lane;
      level <= next_level;
      fails <= next_fails;
      hold <= next_hold;
      tmo <= next_tmo;
      idx <= next_idx;
      apply <= next_apply;
      paddr <= next_paddr;
      pwdata <= next_pwdata;
      psel <= next_state inside {sfr_pkg::ST_SETUP, sfr_pkg::ST_ACCESS};
      penable <= (next_state == sfr_pkg::ST_ACCESS);
      pwrite <= next_state inside {sfr_pkg::ST_SETUP, sfr_pkg::ST_ACCESS};
      lane_down <= next_lane_down;
      // core reset replaces the lane request in the pcie and xaui modes
      lane_soft_reset_request <= (next_soft && !ctrl[sfr_pkg::CTRL_PCIE_XAUI]) ? next_onehot : '0;
      core_reset_low <= !(next_soft && ctrl[sfr_pkg::CTRL_PCIE_XAUI]);
      lane_pcs_reset_low <= in_phy ? ~next_onehot : '1;
      init_reset_low <= (next_state != sfr_pkg::ST_INIT);
    end
  end
endmodule

// ==== test/sfr_checker.sv ====
// port assertions of the fault recovery controller
`timescale 1ns/1ps
module sfr_checker (
  input logic mclk,
  input logic rst_n,
  input logic [3:0] lane_soft_reset_request,
  input logic [3:0] lane_pcs_reset_low,
  input logic init_reset_low,
  input logic [15:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic pready
);
  // hold figures assume the bench programs a hold of 4 cycles
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_soft_hold: assert property ($rose(lane_soft_reset_request[0]) |->
    lane_soft_reset_request[0] [*4] ##1 !lane_soft_reset_request[0]) else $error("soft hold");
  chk_init_hold: assert property ($fell(init_reset_low) |-> !init_reset_low [*4] ##1 init_reset_low)
    else $error("init hold");
  chk_pcs_hold: assert property ($fell(lane_pcs_reset_low[0]) |-> !lane_pcs_reset_low[0] [*4])
    else $error("pcs hold");
  chk_reload_rst: assert property (psel |-> lane_pcs_reset_low != 4'hf) else $error("not in reset");
  chk_apb_access: assert property (psel && !penable |=> psel && penable) else $error("no access");
  chk_apb_wait: assert property (penable && !pready |=> penable && $stable(paddr)) else $error("moved");
  chk_apb_end: assert property (penable && pready |=> !penable) else $error("no end");
  chk_write_only: assert property (psel |-> pwrite) else $error("read");
  cover property ($rose(lane_soft_reset_request[0]));
  cover property (penable && pready);
  cover property ($fell(init_reset_low));
endmodule
bind sfr_top sfr_checker u_chk (.*);

// ==== test/sfr_xcvr_model.sv ====
// transceiver model: configuration slave with shadow and active settings
`timescale 1ns/1ps
module sfr_xcvr_model (
  input logic mclk,
  input logic slow,
  input logic [15:0] paddr,
  input logic penable,
  input logic [31:0] pwdata,
  output logic pready
);
  logic [31:0] shadow [32];
  logic [31:0] active [32];
  logic phase = 1'b0;
  // slow mode answers each access one cycle late
  assign pready = penable & (phase | ~slow);
  // writes wait in shadow storage; an apply moves a whole lane pair
  always @(posedge mclk)
  begin
    phase <= penable & ~phase;
    if (pready && paddr[9:8] != 2'h3)
      shadow[{paddr[11:10], paddr[4:2]}] <= pwdata;
    for (int i = 0; i < 32; i++)
      if (pready && paddr[9:8] == 2'h3 && pwdata[0] && i[4] == paddr[11])
        active[i] <= shadow[i];
  end
endmodule

// ==== test/sfr_top_bench.sv ====
// self-checking bench of the fault recovery controller
`timescale 1ns/1ps
module sfr_top_bench;
  logic mclk = 1'b0, rst_n = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
  logic irq, core_reset_low, init_reset_low, psel, penable, pwrite, pready;
  logic [5:0] sw_addr = 6'h00;
  logic [31:0] sw_wdata = 32'h0, sw_rdata, pwdata;
  logic [15:0] paddr;
  logic [3:0] cdr_lock = 4'hf, lane_link_up = 4'h0, lane_retry = 4'h0, lane_error = 4'h0;
  logic [3:0] lane_down, lane_soft_reset_request, lane_pcs_reset_low;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  always #20 mclk = ~mclk;
  sfr_top #(.LINK_WAIT_CYCLES(50)) u_dut (.*, .lane_receive_valid(4'hf), .pma_ready(4'hf),
    .domain_pll_lock(1'b1));
  sfr_xcvr_model u_xcvr (.*, .slow(1'b1));
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
      n_fail++;
    if (g !== e)
      $display("BAD t=%0t %h %h", $time, g, e);
  endtask
  // one register cycle; a read compares d with the data of the next cycle
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= w;
    sw_rd <= !w;
    @(posedge mclk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    @(negedge mclk);
    if (!w)
      chk(sw_rdata, d);
  endtask
  // a resent frame is only counted, never a reset
  task t_retry;
    bus(0, 6'h10, 32'h103);
    bus(0, 6'h3c, 32'h0);
    bus(1, 6'h10, 32'h41);
    bus(1, 6'h00, 32'h1);
    @(posedge mclk);
    lane_retry <= 4'h2;
    @(posedge mclk);
    lane_retry <= 4'h0;
    bus(0, 6'h24, 32'h1);
    bus(0, 6'h04, 32'h1);
    chk(lane_soft_reset_request, 32'h0);
    bus(1, 6'h04, 32'h1);
  endtask
  // lane 0 links only after soft, pcs, reload, then initialization reset
  task t_escalate;
    @(posedge mclk);
    cdr_lock <= 4'he;
    for (int i = 0; i < 4000 && init_reset_low !== 1'b0; i++)
      @(negedge mclk);
    chk(init_reset_low, 32'h0);
    chk(u_xcvr.active[3], 32'ha3);
    @(posedge mclk);
    cdr_lock <= 4'hf;
    lane_link_up <= 4'hf;
    for (int i = 0; i < 400 && lane_down !== 4'h0; i++)
      @(negedge mclk);
    bus(0, 6'h04, 32'h1e);
  endtask
  // a burst on lane 2 is a disconnection; lane 3 runs on its receive clock
  task t_burst;
    bus(1, 6'h04, 32'h1f);
    bus(1, 6'h0c, 32'h00010002);
    bus(1, 6'h14, 32'h802);
    @(posedge mclk);
    lane_error <= 4'h4;
    repeat (3) @(posedge mclk);
    lane_error <= 4'h0;
    for (int i = 0; i < 20 && lane_soft_reset_request !== 4'h4; i++)
      @(negedge mclk);
    chk(lane_soft_reset_request, 32'h4);
    chk(lane_down, 32'hc);
    chk(core_reset_low, 32'h1);
    for (int i = 0; i < 400 && lane_down !== 4'h0; i++)
      @(negedge mclk);
    bus(0, 6'h04, 32'h12);
  endtask
  task t_irq;
    bus(1, 6'h08, 32'h10);
    @(negedge mclk);
    chk(irq, 32'h1);
    bus(1, 6'h04, 32'h10);
    @(negedge mclk);
    chk(irq, 32'h0);
  endtask
  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, far beyond the escalation time
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run;
    end
  end
  // reference copy is loaded before the controller is enabled
  initial
  begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    bus(1, 6'h18, 32'h0);
    for (int i = 0; i < 8; i++)
      bus(1, 6'h1c, 32'ha0 + i);
    t_retry;
    t_escalate;
    t_burst;
    t_irq;
    complete_run;
  end
endmodule
